// file: shared/e1_ctl_pkg.sv
// Shared constants and types for the E1 loopback and receive store control
package e1_ctl_pkg;

	// ------------------------------------------------------------------
	// Host port
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} host_req_t;

	localparam logic [ADDR_W-1:0] OFS_LOOP_CTRL = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CTRL_FOUR = 8'h15;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_MONITOR   = 8'h41;

	localparam logic [DATA_W-1:0] LOOP_CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_FOUR_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO       = 8'h00;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BIT_LOOP      = 6;
	localparam int BIT_LI_RST    = 7;
	localparam int BIT_ALIGN     = 6;
	localparam int BIT_DEPTH_RST = 5;
	localparam int MON_SEL_MSB   = 4;
	localparam int MON_SEL_LSB   = 0;
	localparam int MON_SEL_W     = MON_SEL_MSB - MON_SEL_LSB + 1;
	localparam int ST_LOCKED     = 0;
	localparam int ST_LOOP       = 1;
	localparam int ST_SEP_OK     = 2;
	localparam int ST_FLUSHING   = 3;
	localparam int ST_JA_FULL    = 4;

	// ------------------------------------------------------------------
	// Line, store and recovery sizing
	// ------------------------------------------------------------------
	typedef struct packed {
		logic pos;
		logic neg;
	} line_pair_t;

	localparam int FRAME_BITS   = 256;
	localparam int STORE_FRAMES = 2;
	localparam int SLOT_BITS    = 8;
	localparam int SYNC_STAGES  = 3;
	localparam int JA_DEPTH     = 16;
	localparam int LOCK_MARKS   = 8;

	typedef enum logic [1:0] {
		REC_RESET = 2'b00,
		REC_HUNT  = 2'b01,
		REC_LOCK  = 2'b10
	} rec_state_t;

endpackage : e1_ctl_pkg

// file: rtl/rx_slip_store.sv
// Receive elastic store with align and depth reset
`timescale 1ns/1ps
module rx_slip_store #(
	parameter int DEPTH = e1_ctl_pkg::FRAME_BITS * e1_ctl_pkg::STORE_FRAMES,
	parameter int FRAME = e1_ctl_pkg::FRAME_BITS
) (
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	input  wire logic                     wr_en,
	input  wire logic                     wr_bit,
	input  wire logic                     rd_en,
	input  wire logic                     align_req,
	input  wire logic                     depth_rst_req,
	output logic                          rd_bit,
	output logic                          rd_valid,
	output logic [$clog2(DEPTH)-1:0]      rd_pos,
	output logic                          sep_ok,
	output logic                          flushing
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] HALF_P  = PW'(FRAME / 2);
	localparam logic [PW-1:0] FRAME_P = PW'(FRAME);

	logic          mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW-1:0] sep;
	logic [PW-1:0] flush_left;
	logic [PW-1:0] next_wr_ptr;
	logic [PW-1:0] next_rd_ptr;
	logic [PW-1:0] next_flush_left;
	logic [PW-1:0] next_rd_pos;
	logic          next_rd_bit;
	logic          next_rd_valid;

	assign sep      = wr_ptr - rd_ptr;
	assign sep_ok   = (sep >= HALF_P);
	assign flushing = (flush_left != '0);

	// ------------------------------------------------------------------
	// Pointer control
	// ------------------------------------------------------------------
	always_comb
	begin
		next_wr_ptr     = wr_en ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr     = rd_en ? rd_ptr + 1'b1 : rd_ptr;
		next_flush_left = flush_left;
		next_rd_bit     = 1'b0;
		next_rd_valid   = 1'b0;
		next_rd_pos     = rd_pos;
		if (rd_en)
		begin
			next_rd_pos = rd_ptr;
			// Stale bits left over by a depth reset are dropped
			if (flush_left != '0)
				next_flush_left = flush_left - 1'b1;
			else
			begin
				next_rd_bit   = mem[rd_ptr];
				next_rd_valid = 1'b1;
			end
		end
		// Depth reset outranks align; depth reset always, and align only under half a frame of separation, set the read pointer back from the write pointer
		if (depth_rst_req)
		begin
			next_rd_ptr     = next_wr_ptr - FRAME_P;
			next_flush_left = FRAME_P;
			next_rd_bit     = 1'b0;
			next_rd_valid   = 1'b0;
		end
		else if (align_req && (sep < HALF_P))
			next_rd_ptr = next_wr_ptr - HALF_P;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			flush_left <= '0;
			rd_bit     <= 1'b0;
			rd_valid   <= 1'b0;
			rd_pos     <= '0;
		end
		else
		begin
			wr_ptr     <= next_wr_ptr;
			rd_ptr     <= next_rd_ptr;
			flush_left <= next_flush_left;
			rd_bit     <= next_rd_bit;
			rd_valid   <= next_rd_valid;
			rd_pos     <= next_rd_pos;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
			mem[wr_ptr] <= wr_bit;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_align_sets_half: assert property (@(posedge sys_clk) disable iff (reset)
		(align_req && !depth_rst_req && sep < HALF_P) |=> sep == HALF_P)
		else $error("align did not set half frame separation");
	a_align_no_action: assert property (@(posedge sys_clk) disable iff (reset)
		(align_req && !depth_rst_req && sep >= HALF_P)
		|=> (rd_ptr - $past(rd_ptr)) == PW'($past(rd_en)))
		else $error("align moved read pointer with enough separation");
	a_depth_one_frame: assert property (@(posedge sys_clk) disable iff (reset)
		depth_rst_req |=> sep == FRAME_P)
		else $error("depth reset did not give one frame");
	a_reset_discards: assert property (@(posedge sys_clk) disable iff (reset)
		depth_rst_req |=> (!rd_valid && flushing) ##1 !rd_valid)
		else $error("stale data delivered after depth reset");

endmodule : rx_slip_store

// file: rtl/e1_local_loopback_and_rx_store_control.sv
// Local loopback, common control register four and receive store control
`timescale 1ns/1ps
module e1_local_loopback_and_rx_store_control #(
	parameter int JA_DEPTH   = e1_ctl_pkg::JA_DEPTH,
	parameter int LOCK_MARKS = e1_ctl_pkg::LOCK_MARKS
) (
	input  wire logic                            sys_clk,
	input  wire logic                            reset,
	input  wire e1_ctl_pkg::host_req_t           host_req,
	output logic [e1_ctl_pkg::DATA_W-1:0]        host_rdata,
	input  wire e1_ctl_pkg::line_pair_t          tx_data,
	output e1_ctl_pkg::line_pair_t               line_tx,
	input  wire logic                            line_rx_pos,
	input  wire logic                            line_rx_neg,
	input  wire logic                            rx_bit_strobe,
	input  wire logic                            bp_bit_strobe,
	output logic                                 rx_bp_data,
	output logic                                 rx_bp_valid,
	output logic [e1_ctl_pkg::DATA_W-1:0]        rx_monitor_byte
);
	localparam int STORE_DEPTH = e1_ctl_pkg::FRAME_BITS
		* e1_ctl_pkg::STORE_FRAMES;
	localparam int PW   = $clog2(STORE_DEPTH);
	localparam int FW   = $clog2(JA_DEPTH + 1);
	localparam int LW   = $clog2(LOCK_MARKS + 1);
	localparam int BIW  = $clog2(e1_ctl_pkg::SLOT_BITS);
	localparam int SW   = e1_ctl_pkg::SYNC_STAGES;
	localparam logic [FW-1:0]  JA_FULL_P  = FW'(JA_DEPTH);
	localparam logic [LW-1:0]  LOCK_P     = LW'(LOCK_MARKS);
	localparam logic [BIW-1:0] LAST_BIT_P = BIW'(e1_ctl_pkg::SLOT_BITS - 1);

	// Channel number of a store position
	function automatic logic [e1_ctl_pkg::MON_SEL_W-1:0] chan_of(
		input logic [PW-1:0] pos);
		chan_of = e1_ctl_pkg::MON_SEL_W'(
			(int'(pos) % e1_ctl_pkg::FRAME_BITS) / e1_ctl_pkg::SLOT_BITS);
	endfunction : chan_of

	// Bit index of a store position inside its time slot
	function automatic logic [BIW-1:0] bit_of(input logic [PW-1:0] pos);
		bit_of = BIW'(int'(pos) % e1_ctl_pkg::SLOT_BITS);
	endfunction : bit_of

	// ------------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------------
	logic [e1_ctl_pkg::DATA_W-1:0] loop_ctrl;
	logic [e1_ctl_pkg::DATA_W-1:0] common_control_four;
	logic [e1_ctl_pkg::DATA_W-1:0] next_loop_ctrl;
	logic [e1_ctl_pkg::DATA_W-1:0] next_control_four;
	logic [e1_ctl_pkg::DATA_W-1:0] next_rdata;
	logic [e1_ctl_pkg::DATA_W-1:0] status;
	logic                          ctrl_four_wr;
	logic                          li_pulse;
	logic                          align_pulse;
	logic                          depth_pulse;
	logic                          next_li_pulse;
	logic                          next_align_pulse;
	logic                          next_depth_pulse;
	logic                          near_end_loopback;
	logic [e1_ctl_pkg::MON_SEL_W-1:0] rx_monitor_sel;

	assign near_end_loopback = loop_ctrl[e1_ctl_pkg::BIT_LOOP];
	assign rx_monitor_sel = common_control_four[e1_ctl_pkg::MON_SEL_MSB:
		e1_ctl_pkg::MON_SEL_LSB];
	assign ctrl_four_wr = host_req.wr
		&& (host_req.addr == e1_ctl_pkg::OFS_CTRL_FOUR);

	always_comb
	begin
		next_loop_ctrl    = loop_ctrl;
		next_control_four = common_control_four;
		next_rdata        = e1_ctl_pkg::READ_ZERO;
		if (host_req.wr && host_req.addr == e1_ctl_pkg::OFS_LOOP_CTRL)
			next_loop_ctrl = host_req.wdata;
		if (ctrl_four_wr)
			next_control_four = host_req.wdata;
		// Edge taken against the stored copy, so 1 over 1 is quiet
		next_li_pulse = ctrl_four_wr
			&& host_req.wdata[e1_ctl_pkg::BIT_LI_RST]
			&& !common_control_four[e1_ctl_pkg::BIT_LI_RST];
		next_align_pulse = ctrl_four_wr
			&& host_req.wdata[e1_ctl_pkg::BIT_ALIGN]
			&& !common_control_four[e1_ctl_pkg::BIT_ALIGN];
		next_depth_pulse = ctrl_four_wr
			&& host_req.wdata[e1_ctl_pkg::BIT_DEPTH_RST]
			&& !common_control_four[e1_ctl_pkg::BIT_DEPTH_RST];
		if (host_req.rd)
		begin
			case (host_req.addr)
				e1_ctl_pkg::OFS_LOOP_CTRL: next_rdata = loop_ctrl;
				e1_ctl_pkg::OFS_CTRL_FOUR: next_rdata = common_control_four;
				e1_ctl_pkg::OFS_STATUS:    next_rdata = status;
				e1_ctl_pkg::OFS_MONITOR:   next_rdata = rx_monitor_byte;
				default:                   next_rdata = e1_ctl_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			loop_ctrl           <= e1_ctl_pkg::LOOP_CTRL_RESET;
			common_control_four <= e1_ctl_pkg::CTRL_FOUR_RESET;
			host_rdata          <= e1_ctl_pkg::READ_ZERO;
			li_pulse            <= 1'b0;
			align_pulse         <= 1'b0;
			depth_pulse         <= 1'b0;
		end
		else
		begin
			loop_ctrl           <= next_loop_ctrl;
			common_control_four <= next_control_four;
			host_rdata          <= next_rdata;
			li_pulse            <= next_li_pulse;
			align_pulse         <= next_align_pulse;
			depth_pulse         <= next_depth_pulse;
		end
	end

	// ------------------------------------------------------------------
	// Line input synchroniser and transmit path
	// ------------------------------------------------------------------
	logic [SW-1:0]          rx_pos_sync;
	logic [SW-1:0]          rx_neg_sync;
	e1_ctl_pkg::line_pair_t line_clean;
	e1_ctl_pkg::line_pair_t next_line_clean;

	// A level counts only once the two last stages agree
	always_comb
	begin
		next_line_clean = line_clean;
		if (rx_pos_sync[SW-1] == rx_pos_sync[SW-2])
			next_line_clean.pos = rx_pos_sync[SW-1];
		if (rx_neg_sync[SW-1] == rx_neg_sync[SW-2])
			next_line_clean.neg = rx_neg_sync[SW-1];
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rx_pos_sync <= '0;
			rx_neg_sync <= '0;
			line_clean  <= '0;
			line_tx     <= '0;
		end
		else
		begin
			rx_pos_sync <= {rx_pos_sync[SW-2:0], line_rx_pos};
			rx_neg_sync <= {rx_neg_sync[SW-2:0], line_rx_neg};
			line_clean  <= next_line_clean;
			line_tx     <= tx_data;
		end
	end

	// ------------------------------------------------------------------
	// Jitter attenuator and receive source select
	// ------------------------------------------------------------------
	e1_ctl_pkg::line_pair_t ja_mem      [JA_DEPTH];
	e1_ctl_pkg::line_pair_t next_ja_mem [JA_DEPTH];
	e1_ctl_pkg::line_pair_t ja_out;
	e1_ctl_pkg::line_pair_t rx_src;
	logic [FW-1:0]          ja_fill;
	logic [FW-1:0]          next_ja_fill;
	logic                   ja_full;

	assign ja_out  = ja_mem[JA_DEPTH-1];
	assign ja_full = (ja_fill == JA_FULL_P);
	// Looped data comes off the attenuator, never the line pins
	assign rx_src  = near_end_loopback ? ja_out : line_clean;

	always_comb
	begin
		next_ja_mem[0] = line_tx;
		for (int i = 1; i < JA_DEPTH; i++)
			next_ja_mem[i] = ja_mem[i-1];
		next_ja_fill = ja_full ? ja_fill : ja_fill + 1'b1;
		if (li_pulse)
		begin
			for (int i = 0; i < JA_DEPTH; i++)
				next_ja_mem[i] = '0;
			next_ja_fill = '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < JA_DEPTH; i++)
				ja_mem[i] <= '0;
			ja_fill <= '0;
		end
		else
		begin
			ja_mem  <= next_ja_mem;
			ja_fill <= next_ja_fill;
		end
	end

	// ------------------------------------------------------------------
	// Clock recovery state machine
	// ------------------------------------------------------------------
	e1_ctl_pkg::rec_state_t rec_state;
	e1_ctl_pkg::rec_state_t next_rec_state;
	logic [LW-1:0]          mark_count;
	logic [LW-1:0]          next_mark_count;
	logic                   rx_mark;

	assign rx_mark = rx_src.pos | rx_src.neg;

	always_comb
	begin
		next_rec_state  = rec_state;
		next_mark_count = mark_count;
		case (rec_state)
			e1_ctl_pkg::REC_RESET:
			begin
				next_mark_count = '0;
				next_rec_state  = e1_ctl_pkg::REC_HUNT;
			end
			e1_ctl_pkg::REC_HUNT:
			begin
				if (rx_bit_strobe && rx_mark)
					next_mark_count = mark_count + 1'b1;
				if (mark_count == LOCK_P)
					next_rec_state = e1_ctl_pkg::REC_LOCK;
			end
			e1_ctl_pkg::REC_LOCK: next_rec_state = e1_ctl_pkg::REC_LOCK;
			default:              next_rec_state = e1_ctl_pkg::REC_RESET;
		endcase
		if (li_pulse)
		begin
			next_rec_state  = e1_ctl_pkg::REC_RESET;
			next_mark_count = '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rec_state  <= e1_ctl_pkg::REC_RESET;
			mark_count <= '0;
		end
		else
		begin
			rec_state  <= next_rec_state;
			mark_count <= next_mark_count;
		end
	end

	// ------------------------------------------------------------------
	// Elastic store and channel monitor
	// ------------------------------------------------------------------
	logic [PW-1:0] rd_pos;
	logic          sep_ok;
	logic          flushing;
	// Seven earlier bits of the slot; the eighth completes the byte
	logic [e1_ctl_pkg::DATA_W-2:0] mon_shift;
	logic [e1_ctl_pkg::DATA_W-2:0] next_mon_shift;
	logic [e1_ctl_pkg::DATA_W-1:0] next_monitor;
	logic          mon_hit;

	rx_slip_store #(
		.DEPTH (STORE_DEPTH),
		.FRAME (e1_ctl_pkg::FRAME_BITS)
	) u_store (
		.sys_clk       (sys_clk),
		.reset         (reset),
		.wr_en         (rx_bit_strobe),
		.wr_bit        (rx_mark),
		.rd_en         (bp_bit_strobe),
		.align_req     (align_pulse),
		.depth_rst_req (depth_pulse),
		.rd_bit        (rx_bp_data),
		.rd_valid      (rx_bp_valid),
		.rd_pos        (rd_pos),
		.sep_ok        (sep_ok),
		.flushing      (flushing)
	);

	assign mon_hit = rx_bp_valid && (chan_of(rd_pos) == rx_monitor_sel);

	always_comb
	begin
		next_mon_shift = mon_shift;
		next_monitor   = rx_monitor_byte;
		if (mon_hit)
		begin
			next_mon_shift = {mon_shift[e1_ctl_pkg::DATA_W-3:0],
				rx_bp_data};
			if (bit_of(rd_pos) == LAST_BIT_P)
				next_monitor = {mon_shift, rx_bp_data};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			mon_shift       <= '0;
			rx_monitor_byte <= e1_ctl_pkg::READ_ZERO;
		end
		else
		begin
			mon_shift       <= next_mon_shift;
			rx_monitor_byte <= next_monitor;
		end
	end

	always_comb
	begin
		status = e1_ctl_pkg::READ_ZERO;
		status[e1_ctl_pkg::ST_LOCKED]   = (rec_state == e1_ctl_pkg::REC_LOCK);
		status[e1_ctl_pkg::ST_LOOP]     = near_end_loopback;
		status[e1_ctl_pkg::ST_SEP_OK]   = sep_ok;
		status[e1_ctl_pkg::ST_FLUSHING] = flushing;
		status[e1_ctl_pkg::ST_JA_FULL]  = ja_full;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_tx_passes_through: assert property (@(posedge sys_clk) disable iff (reset)
		!$past(reset) |-> line_tx == $past(tx_data))
		else $error("transmit data altered on the line");
	a_loop_uses_tx: assert property (@(posedge sys_clk) disable iff (reset)
		(near_end_loopback && ja_full) |-> rx_src == $past(line_tx, JA_DEPTH))
		else $error("looped data not delayed transmit data");
	a_line_when_normal: assert property (@(posedge sys_clk) disable iff (reset)
		!near_end_loopback |-> rx_src == line_clean)
		else $error("line input not used outside loopback");
	a_li_reset_acts: assert property (@(posedge sys_clk) disable iff (reset)
		(ctrl_four_wr && host_req.wdata[e1_ctl_pkg::BIT_LI_RST]
		&& !common_control_four[e1_ctl_pkg::BIT_LI_RST])
		|=> ##1 (rec_state == e1_ctl_pkg::REC_RESET && ja_fill == '0))
		else $error("line reset did not clear recovery");
	a_trigger_edge_only: assert property (@(posedge sys_clk) disable iff (reset)
		(ctrl_four_wr && common_control_four[e1_ctl_pkg::BIT_ALIGN])
		|=> !align_pulse)
		else $error("align fired on a rewrite of one");
	a_monitor_loads: assert property (@(posedge sys_clk) disable iff (reset)
		(mon_hit && bit_of(rd_pos) == LAST_BIT_P)
		|=> rx_monitor_byte == {$past(mon_shift), $past(rx_bp_data)})
		else $error("monitor byte not loaded from selected channel");

endmodule : e1_local_loopback_and_rx_store_control

// file: dv/testbench.sv
// Self-checking bench for the loopback and receive store control block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	localparam int LIMIT = 20000;
	logic                   sys_clk;
	logic                   reset;
	e1_ctl_pkg::host_req_t  host_req;
	logic [7:0]             host_rdata;
	e1_ctl_pkg::line_pair_t tx_data;
	e1_ctl_pkg::line_pair_t line_tx;
	logic                   line_rx_pos;
	logic                   line_rx_neg;
	logic                   rx_bit_strobe;
	logic                   bp_bit_strobe;
	logic                   rx_bp_data;
	logic                   rx_bp_valid;
	logic [7:0]             rx_monitor_byte;
	logic [7:0]             rd;
	logic                   exp_bit;
	int                     n_mismatch;
	int                     checks;
	int                     cyc;
	int                     n_valid;
	int                     n_bad;

	e1_local_loopback_and_rx_store_control #(
		.LOCK_MARKS(4)
	) i_e1_local_loopback_and_rx_store_control (
		.sys_clk        (sys_clk),
		.reset          (reset),
		.host_req       (host_req),
		.host_rdata     (host_rdata),
		.tx_data        (tx_data),
		.line_tx        (line_tx),
		.line_rx_pos    (line_rx_pos),
		.line_rx_neg    (line_rx_neg),
		.rx_bit_strobe  (rx_bit_strobe),
		.bp_bit_strobe  (bp_bit_strobe),
		.rx_bp_data     (rx_bp_data),
		.rx_bp_valid    (rx_bp_valid),
		.rx_monitor_byte(rx_monitor_byte)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Running totals only; scenarios take differences, never clear them
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (rx_bp_valid === 1'b1)
		begin
			n_valid <= n_valid + 1;
			if (rx_bp_data !== exp_bit)
				n_bad <= n_bad + 1;
		end
		if (cyc == LIMIT)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------------
	// Host port and stream tasks
	// ------------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		host_req.wr <= 1'b0;
		// Let the trigger pulse land before anyone looks
		repeat (2) @(posedge sys_clk);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		host_req.rd <= 1'b0;
		#1 d = host_rdata;
	endtask : rd_reg

	task automatic chk_st(input logic [7:0] mask, input logic [7:0] e);
		rd_reg(e1_ctl_pkg::OFS_STATUS, rd);
		`CHK(rd & mask, e)
	endtask : chk_st

	task automatic stream(input int n, input logic w, input logic r);
		repeat (n)
		begin
			@(posedge sys_clk);
			rx_bit_strobe <= w;
			bp_bit_strobe <= r;
		end
		@(posedge sys_clk);
		rx_bit_strobe <= 1'b0;
		bp_bit_strobe <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : stream

	// Depth reset, then one stale frame, then fresh bits of one value
	task automatic run_discard(input logic b, input logic [7:0] cmd,
		input logic [7:0] mon);
		int v0;
		int b0;
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h00);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, cmd);
		exp_bit = b;
		v0 = n_valid;
		b0 = n_bad;
		stream(256, 1'b1, 1'b1);
		`CHK(n_valid - v0, 0)
		stream(64, 1'b1, 1'b1);
		`CHK(n_valid - v0, 64)
		`CHK(n_bad - b0, 0)
		rd_reg(e1_ctl_pkg::OFS_MONITOR, rd);
		`CHK(rd, mon)
	endtask : run_discard

	task automatic give_verdict();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		host_req = '0;
		tx_data = '0;
		line_rx_pos = 1'b0;
		line_rx_neg = 1'b0;
		rx_bit_strobe = 1'b0;
		bp_bit_strobe = 1'b0;
		exp_bit = 1'b0;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		n_valid = 0;
		n_bad = 0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;

		rd_reg(e1_ctl_pkg::OFS_CTRL_FOUR, rd);
		`CHK(rd, e1_ctl_pkg::CTRL_FOUR_RESET)
		wr_reg(8'h7F, 8'hA5);
		rd_reg(8'h7F, rd);
		`CHK(rd, e1_ctl_pkg::READ_ZERO)
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h1F);
		rd_reg(e1_ctl_pkg::OFS_CTRL_FOUR, rd);
		`CHK(rd, 8'h1F)
		$display("test registers done");

		wr_reg(e1_ctl_pkg::OFS_LOOP_CTRL, 8'h40);
		chk_st(8'h02, 8'h02);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			tx_data <= e1_ctl_pkg::line_pair_t'(i[1:0]);
			@(posedge sys_clk);
			#1 `CHK(line_tx, e1_ctl_pkg::line_pair_t'(i[1:0]))
		end
		tx_data <= 2'b10;
		repeat (30) @(posedge sys_clk);
		// Channel 3 is read from positions 24..31 of the fresh bits
		run_discard(1'b1, 8'h23, 8'hFF);
		$display("test loopback done");

		chk_st(8'h01, 8'h01);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h80);
		chk_st(8'h01, 8'h00);
		stream(16, 1'b1, 1'b0);
		chk_st(8'h01, 8'h01);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h80);
		chk_st(8'h01, 8'h01);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h00);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h80);
		chk_st(8'h01, 8'h00);
		$display("test line reset done");

		wr_reg(e1_ctl_pkg::OFS_LOOP_CTRL, 8'h00);
		repeat (30) @(posedge sys_clk);
		// Fresh bits now sit at positions 336..399, so watch channel 10
		run_discard(1'b0, 8'h2A, 8'h00);
		$display("test normal receive done");

		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h00);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h20);
		chk_st(8'h04, 8'h04);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h60);
		stream(128, 1'b0, 1'b1);
		chk_st(8'h04, 8'h04);
		stream(1, 1'b0, 1'b1);
		chk_st(8'h04, 8'h00);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h20);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h60);
		chk_st(8'h04, 8'h04);
		stream(100, 1'b0, 1'b1);
		chk_st(8'h04, 8'h00);
		wr_reg(e1_ctl_pkg::OFS_CTRL_FOUR, 8'h60);
		chk_st(8'h04, 8'h00);
		$display("test align done");
		give_verdict();
	end
endmodule : testbench
